// [stream_packet_builder_consts.vh]
// Constants for the stream packet builder: register map, fields, resets.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`ifndef STREAM_PACKET_BUILDER_CONSTS_VH
`define STREAM_PACKET_BUILDER_CONSTS_VH

// Register byte offsets
`define CTRL_OFS        8'h00
`define PKT_LEN_OFS     8'h04
`define STATUS_OFS      8'h08
`define IRQ_STAT_OFS    8'h0c
`define IRQ_MASK_OFS    8'h10

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      1'h1

// Status / interrupt fields
`define IRQ_DONE_BIT    0
`define IRQ_ILLEGAL_BIT 1
`define IRQ_MASK_RESET  2'h0

// Source select codes
`define SRC_ETH_HDR     4'h0
`define SRC_SAMPLE      4'h1
`define SRC_PAYLOAD_1   4'h2

// Payload header length in bytes
`define PAYLOAD_HDR_LEN 11'h003

`endif

// [stream_packet_builder.v]
// Builds one streaming packet per start: Ethernet header, payload header,
// then 16-bit samples split into bytes toward the packet byte FIFO.
// Assumes the sample FIFO is first-word-fall-through, the header ROM and
// byte multiplexer sit outside, and start comes from same-clock logic.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "stream_packet_builder_consts.vh"

module stream_packet_builder #(
	parameter [10:0] PKT_LEN = 11'd1024,	// Bytes per packet, default
	parameter [5:0]  HDR_LEN = 6'd14	// Ethernet header bytes
) (
	input  wire        clk_in,			// 250 MHz clock
	input  wire        rstn_in,			// Async reset, active low
	input  wire        clk_en_in,			// Freezes all state except the reset sync flops when low
	input  wire        start_in,			// Start one packet
	input  wire [3:0]  packet_index_in,		// Packet number 1..4
	input  wire        flag_clear_in,		// Clears illegal flag
	input  wire        psel_in,			// APB select
	input  wire        penable_in,			// APB enable
	input  wire        pwrite_in,			// APB write
	input  wire [7:0]  paddr_in,			// APB byte address
	input  wire [31:0] pwdata_in,			// APB write data
	output wire [31:0] prdata_out,			// APB read data
	output wire        pready_out,			// APB ready
	output wire        pslverr_out,		// APB error, unmapped
	output wire        sample_read_en_out,		// Sample FIFO pop
	output wire        byte_phase_out,		// High selects low byte
	output wire        packet_done_out,		// One-cycle done pulse
	output wire [5:0]  header_rom_addr_out,	// Header ROM address
	output wire        write_valid_n_out,		// Low: write byte
	output wire [3:0]  source_select_out,		// Byte mux select
	output wire        illegal_state_flag_out,	// Sticky illegal state
	output wire        irq_out			// Level interrupt
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_HEAD = 6'h02;
	localparam [5:0] ST_PHDR = 6'h04;
	localparam [5:0] ST_DLO  = 6'h08;
	localparam [5:0] ST_DHI  = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `CTRL_OFS) || (a == `PKT_LEN_OFS) ||
				(a == `STATUS_OFS) || (a == `IRQ_STAT_OFS) ||
				(a == `IRQ_MASK_OFS);
		end
	endfunction

	// Reset release through two flops
	reg        rst_s1_q;
	reg        rst_s2_q;
	wire       rstn = rst_s2_q;

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	reg  [5:0]  state_q;
	reg  [5:0]  state_d;
	reg  [10:0] cnt_q;
	reg  [10:0] cnt_d;
	reg         illegal_q;
	reg         bad_state;
	reg         enable_q;
	reg  [10:0] len_q;
	reg  [1:0]  irq_stat_q;
	reg  [1:0]  irq_mask_q;
	reg  [31:0] prdata_q;
	reg         pslverr_q;

	wire [10:0] len_m1   = len_q - 11'd1;
	wire [10:0] hdr_last = {5'h00, HDR_LEN} - 11'd1;
	wire [10:0] phdr_last = {5'h00, HDR_LEN} + `PAYLOAD_HDR_LEN - 11'd1;
	wire        at_end   = (cnt_q == len_m1);
	wire        acc      = psel_in & penable_in;
	wire        setup    = psel_in & ~penable_in;
	wire        wr       = acc & pwrite_in;
	wire        rd_stat  = acc & ~pwrite_in & (paddr_in == `IRQ_STAT_OFS);

	// Next state
	always @* begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		bad_state = 1'b0;
		case (state_q)
		ST_IDLE: begin
			cnt_d = 11'd0;
			if (start_in && enable_q)
				state_d = ST_HEAD;
		end
		ST_HEAD: begin
			cnt_d = cnt_q + 11'd1;
			if (cnt_q == hdr_last)
				state_d = ST_PHDR;
		end
		ST_PHDR: begin
			cnt_d = cnt_q + 11'd1;
			if (cnt_q == phdr_last)
				state_d = ST_DLO;
		end
		ST_DLO: begin
			cnt_d = cnt_q + 11'd1;
			if (at_end)
				state_d = ST_DONE;
			else
				state_d = ST_DHI;
		end
		ST_DHI: begin
			cnt_d = cnt_q + 11'd1;
			if (at_end)
				state_d = ST_DONE;
			else
				state_d = ST_DLO;
		end
		ST_DONE: begin
			state_d = ST_IDLE;
		end
		default: begin
			bad_state = 1'b1;
			state_d   = ST_IDLE;
			cnt_d     = 11'd0;
		end
		endcase
	end

	always @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			state_q   <= ST_IDLE;
			cnt_q     <= 11'd0;
			illegal_q <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (bad_state)
				illegal_q <= 1'b1;
			else if (flag_clear_in)
				illegal_q <= 1'b0;
		end
	end

	// Register file
	always @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			enable_q   <= `CTRL_RESET;
			len_q      <= 11'd0;
			irq_mask_q <= `IRQ_MASK_RESET;
			irq_stat_q <= 2'h0;
			prdata_q   <= 32'h0000_0000;
			pslverr_q  <= 1'b0;
		end else if (clk_en_in) begin
			if (len_q == 11'd0)
				len_q <= PKT_LEN;
			if (wr && paddr_in == `CTRL_OFS)
				enable_q <= pwdata_in[`CTRL_ENABLE_BIT];
			if (wr && paddr_in == `PKT_LEN_OFS && pwdata_in[10:0] != 11'd0)
				len_q <= pwdata_in[10:0];
			if (wr && paddr_in == `IRQ_MASK_OFS)
				irq_mask_q <= pwdata_in[1:0];
			irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) |
				{bad_state, state_q == ST_DONE};
			if (setup) begin
				pslverr_q <= ~mapped(paddr_in);
				case (paddr_in)
				`CTRL_OFS:     prdata_q <= {31'h0, enable_q};
				`PKT_LEN_OFS:  prdata_q <= {21'h0, len_q};
				`STATUS_OFS:   prdata_q <= {cnt_q, 13'h0, state_q,
						1'b0, illegal_q};
				`IRQ_STAT_OFS: prdata_q <= {30'h0, irq_stat_q};
				`IRQ_MASK_OFS: prdata_q <= {30'h0, irq_mask_q};
				default:       prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata_out  = prdata_q;
	assign pready_out  = 1'b1;
	assign pslverr_out = pslverr_q & acc;
	assign irq_out     = |(irq_stat_q & irq_mask_q);

	// Outputs decoded from state, count and packet index; flag from illegal_q
	assign header_rom_addr_out = cnt_q[5:0];
	assign write_valid_n_out = ~(state_q == ST_HEAD || state_q == ST_PHDR ||
		state_q == ST_DLO || state_q == ST_DHI);
	assign byte_phase_out = (state_q == ST_DLO);
	assign sample_read_en_out = (state_q == ST_DHI) ||
		(state_q == ST_DLO && at_end);
	assign source_select_out = (state_q == ST_PHDR) ?
		(`SRC_PAYLOAD_1 + packet_index_in - 4'h1) :
		((state_q == ST_DLO || state_q == ST_DHI) ?
		`SRC_SAMPLE : `SRC_ETH_HDR);
	assign packet_done_out = (state_q == ST_DONE);
	assign illegal_state_flag_out = illegal_q;

endmodule // stream_packet_builder
`default_nettype wire

// [spb_properties.sv]
// Checker for packet builder port timing
// Assumes the builder top ports; clock enable held high
`timescale 1ns/1ps
`default_nettype none
module spb_properties(
	input wire       clk_in, rstn_in, clk_en_in, flag_clear_in,
	input wire       sample_read_en_out, byte_phase_out,
	input wire       packet_done_out, write_valid_n_out,
	input wire       illegal_state_flag_out,
	input wire [3:0] source_select_out
);
	wire       w = !write_valid_n_out;
	wire [3:0] s = source_select_out;
	wire       f = illegal_state_flag_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in || !clk_en_in);
	property p_rd; sample_read_en_out |-> w && !byte_phase_out; endproperty
	a_rd: assert property (p_rd) else $error("read off phase");
	property p_rate; sample_read_en_out |=> !sample_read_en_out; endproperty
	a_rate: assert property (p_rate) else $error("read rate");
	property p_alt; w && byte_phase_out |=> w && !byte_phase_out && s == 4'h1;
	endproperty
	a_alt: assert property (p_alt) else $error("phase order");
	property p_sel; w |-> s <= 4'h5; endproperty
	a_sel: assert property (p_sel) else $error("select code");
	property p_ord;
		w && s == 4'h1 && $past(s) != 4'h1 |-> $past(s) > 4'h1 && $past(s, 3) > 4'h1;
	endproperty
	a_ord: assert property (p_ord) else $error("data too early");
	property p_done; packet_done_out |-> !w ##1 !packet_done_out; endproperty
	a_done: assert property (p_done) else $error("done pulse");
	property p_flag; f && !flag_clear_in |=> f; endproperty
	a_flag: assert property (p_flag) else $error("flag lost");
	property p_clr; flag_clear_in |=> !f; endproperty
	a_clr: assert property (p_clr) else $error("flag kept");
endmodule // spb_properties
bind stream_packet_builder spb_properties i_spb_properties(
	.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
	.flag_clear_in(flag_clear_in), .sample_read_en_out(sample_read_en_out),
	.byte_phase_out(byte_phase_out), .packet_done_out(packet_done_out),
	.write_valid_n_out(write_valid_n_out),
	.illegal_state_flag_out(illegal_state_flag_out),
	.source_select_out(source_select_out));
`default_nettype wire

// [seq_model.sv]
// Group sequencer model: starts packets 1..4 in turn
// Assumes the builder shares its clock
`timescale 1ns/1ps
`default_nettype none
module seq_model(
	input  wire       clk_in, run_in, done_in,
	output reg        start_out,
	output reg  [3:0] index_out
);
	reg busy_q = 1'h0;
	initial start_out = 1'h0;
	initial index_out = 4'h1;
	always @(posedge clk_in) begin
		start_out <= run_in && !busy_q && !start_out;
		busy_q <= run_in && (start_out || (busy_q && !done_in));
		if (done_in)
			index_out <= (index_out == 4'h4) ? 4'h1 : index_out + 4'h1;
	end
endmodule // seq_model
`default_nettype wire

// [testbench.sv]
// Bench for the packet builder: APB tasks and packet counts
// Assumes seq_model as sequencer and a short packet length
`timescale 1ns/1ps
`default_nettype none
`include "stream_packet_builder_consts.vh"
module testbench;
	localparam [10:0] LEN = 11'h021;
	reg        clk_in = 1'h0, rstn_in = 1'h0, run = 1'h0, clr = 1'h0;
	reg        psel = 1'h0, pen = 1'h0, pwr = 1'h0, e;
	reg [7:0]  padr = 8'h00;
	reg [31:0] pwd = 32'h0, rd;
	reg [3:0]  ls = 4'h0;
	wire [31:0] prd;
	wire       rdy, err, re, ph, done, vn, flag, irq, start;
	wire [3:0] idx, sel;
	wire [5:0] ra;
	integer    error_cnt = 0, checks_done = 0, nw = 0, nr = 0, cyc = 0, np = 0;
	always #2 clk_in = !clk_in;
	stream_packet_builder #(.PKT_LEN(LEN)) i_stream_packet_builder(
		.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(1'h1),
		.start_in(start), .packet_index_in(idx), .flag_clear_in(clr),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
		.pslverr_out(err), .sample_read_en_out(re), .byte_phase_out(ph),
		.packet_done_out(done), .header_rom_addr_out(ra),
		.write_valid_n_out(vn), .source_select_out(sel),
		.illegal_state_flag_out(flag), .irq_out(irq));
	seq_model i_seq_model(.clk_in(clk_in), .run_in(run), .done_in(done),
		.start_out(start), .index_out(idx));
	task chk(input string n, input [31:0] x, input [31:0] g);
	begin
		checks_done = checks_done + 1;
		if (x !== g) begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s exp %h got %h", n, x, g);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
	begin
		@(posedge clk_in);
		{psel, pen, pwr, padr, pwd} <= {1'h1, 1'h0, w, a, d};
		@(posedge clk_in);
		pen <= 1'h1;
		n = 0;
		do begin @(posedge clk_in); n = n + 1; end while (rdy !== 1'h1 && n < 50);
		if (n >= 50) begin chk("pready", 1, 0); end_of_test; end
		rd = prd;
		e = err;
		{psel, pen} <= 2'h0;
	end
	endtask
	always @(posedge clk_in) begin
		if (start) begin cyc = 0; nw = 0; nr = 0; end
		else cyc = cyc + 1;
		if (!vn) nw = nw + 1;
		if (re) nr = nr + 1;
		if (!vn && sel > 4'h1) ls = sel;
		if (!vn && sel == 4'h0) chk("romaddr", cyc - 1, ra);
		if (done) begin
			chk("latency", LEN + 1, cyc);
			chk("bytes", LEN, nw);
			chk("reads", (LEN - 17) / 2, nr);
			chk("phdr", idx + 4'h1, ls);
			np = np + 1;
		end
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		apb(1'h0, `CTRL_OFS, 32'h0); chk("ctrl", 1, rd);
		apb(1'h0, `IRQ_MASK_OFS, 32'h0); chk("mask", 0, rd);
		apb(1'h0, 8'h14, 32'h0); chk("slverr", 1, e);
		apb(1'h1, `IRQ_MASK_OFS, 32'h1);
		$display("test regs done");
		run <= 1'h1;
		repeat (400) if (np < 3) @(posedge clk_in);
		repeat (60) if (done !== 1'h1) @(posedge clk_in);
		run <= 1'h0;
		@(posedge clk_in);
		chk("packets", 4, np);
		chk("irq", 1, irq);
		apb(1'h0, `IRQ_STAT_OFS, 32'h0); chk("stat", 1, rd[0]);
		@(negedge clk_in);
		chk("irq clr", 0, irq);
		@(posedge clk_in);
		clr <= 1'h1;
		@(posedge clk_in) clr <= 1'h0;
		chk("flag", 0, flag);
		$display("test packets done");
		apb(1'h1, `CTRL_OFS, 32'h0);
		run <= 1'h1;
		repeat (60) @(posedge clk_in);
		chk("refused", 4, np);
		$display("test disable done");
		end_of_test;
	end
endmodule // testbench
`default_nettype wire
